//--- pbp_port.sv
// peripheral bus port: wait states, 16-bit read bursts, master arbitration
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// How it works
// - address-to-data waits are one more than the old nominal figure for every code.
// - recovery waits are two more than the old nominal figure for every code.
// - bits 4:2 pick 5, 9, 13 or 17 address-to-data waits, other codes 21.
// - bits 8:6 pick 3, 6, 10, 14 or 18 recovery waits, other codes 22.
// - on a 16-bit window every 2-byte and 4-byte read runs as two 16-bit cycles.
// - on a 16-bit window every core read becomes a two-beat burst even if one would do.
// - an 8-bit window never converts reads into two-cycle bursts.
// - a core writing back to back can hold off the other masters from the port.
// - the tenure timer, 98h at reset, limits core back-to-back tenure while others wait, also at its reset value.
module pbp_port
   import pbp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // internal masters: core, dma, translation unit
   input wire pbp_pkg::pbp_req_t [2:0] mst_req_in,
   output logic [2:0] mst_ack_out,
   output logic [31:0] mst_rdata_out,
   // external memory bus
   output pbp_pkg::pbp_mem_t mem_out,
   input wire logic [15:0] mem_din_in
);
   import pbp_pkg::*;
   // ----------------------------------------
   // transfer states, one-hot
   // ----------------------------------------
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_BEAT = 6'b001000,
      ST_DONE = 6'b010000,
      ST_REC = 6'b100000
   } pbp_state_t;
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] win_q [2], win_d [2];
   logic [7:0] tenure_q, tenure_d;
   // unmapped offsets are ignored on write
   always_comb
   begin
      win_d = win_q;
      tenure_d = tenure_q;
      if (reg_wr_in)
      begin
         if (reg_addr_in == PBP_OFF_WIN0)
            win_d[0] = reg_wdata_in;
         if (reg_addr_in == PBP_OFF_WIN1)
            win_d[1] = reg_wdata_in;
         if (reg_addr_in == PBP_OFF_TENURE)
            tenure_d = reg_wdata_in[7:0];
      end
   end
   // ----------------------------------------
   // transfer engine state
   // ----------------------------------------
   pbp_state_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [1:0] own_q, own_d;
   logic wide_q, wide_d;
   logic beat_q, beat_d;
   logic burst_q, burst_d;
   logic [4:0] a2d_q, a2d_d;
   logic [4:0] rec_q, rec_d;
   logic [31:0] data_q, data_d;
   logic [23:0] addr_q, addr_d;
   logic gnt_vld;
   logic [1:0] gnt;
   logic [2:0] req_vec;
   logic hit1;
   logic [2:0] a2d_code, rec_code;
   logic [31:0] win_sel;
   pbp_req_t cur;
   // ----------------------------------------
   // arbiter
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_req
         assign req_vec[gi] = mst_req_in[gi].valid & ~(st_q != ST_IDLE && own_q == 2'(gi));
      end
   endgenerate
   pbp_arb u_arb
   (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .req_in(req_vec),
      .done_in(st_q == ST_DONE),
      .idle_in(st_q == ST_IDLE),
      .tenure_in(tenure_q),
      .gnt_vld_out(gnt_vld),
      .gnt_out(gnt)
   );
   // ----------------------------------------
   // window decode and next state
   // ----------------------------------------
   always_comb
   begin
      cur = mst_req_in[gnt];
      // window 1 claims when enabled and its base matches, else window 0
      hit1 = win_q[1][PBP_WIN_EN_BIT]
         && cur.addr[31:PBP_BASE_LSB] == win_q[1][31:PBP_BASE_LSB];
      win_sel = hit1 ? win_q[1] : win_q[0];
      a2d_code = win_sel[PBP_A2D_MSB:PBP_A2D_LSB];
      rec_code = win_sel[PBP_REC_MSB:PBP_REC_LSB];
      st_d = st_q;
      cnt_d = cnt_q;
      own_d = own_q;
      wide_d = wide_q;
      beat_d = beat_q;
      burst_d = burst_q;
      a2d_d = a2d_q;
      rec_d = rec_q;
      data_d = data_q;
      addr_d = addr_q;
      unique case (st_q)
         ST_IDLE:
         begin
            if (gnt_vld)
            begin
               own_d = gnt;
               wide_d = win_sel[PBP_WIN_W16_BIT];
               // one wait more than nominal, per code
               unique case (a2d_code)
                  3'b000: a2d_d = PBP_A2D_0;
                  3'b001: a2d_d = PBP_A2D_1;
                  3'b010: a2d_d = PBP_A2D_2;
                  3'b011: a2d_d = PBP_A2D_3;
                  default: a2d_d = PBP_A2D_DEF;
               endcase
               // two waits more than nominal, per code
               unique case (rec_code)
                  3'b000: rec_d = PBP_REC_0;
                  3'b001: rec_d = PBP_REC_1;
                  3'b010: rec_d = PBP_REC_2;
                  3'b011: rec_d = PBP_REC_3;
                  3'b100: rec_d = PBP_REC_4;
                  default: rec_d = PBP_REC_DEF;
               endcase
               // 16-bit reads always take two beats; byte reads unsupported there
               burst_d = win_sel[PBP_WIN_W16_BIT] && !cur.write;
               // burst starts on the word boundary so the halves pair up
               addr_d = burst_d ? {cur.addr[23:2], 2'b00} : cur.addr[23:0];
               data_d = cur.wdata;
               beat_d = 1'b0;
               cnt_d = 5'h00;
               st_d = ST_ADDR;
            end
         end
         ST_ADDR:
         begin
            cnt_d = a2d_q;
            st_d = ST_WAIT;
         end
         ST_WAIT:
         begin
            // runs down to 1, so a code gives exactly its waits
            if (cnt_q > 5'h01)
               cnt_d = cnt_q - 5'h01;
            else
               st_d = ST_BEAT;
         end
         ST_BEAT:
         begin
            // data taken at the end of the beat, device still driving
            if (!mst_req_in[own_q].write)
            begin
               if (!wide_q)
                  data_d = {24'h000000, mem_din_in[7:0]};
               else if (!beat_q)
                  data_d[15:0] = mem_din_in;
               else
                  data_d[31:16] = mem_din_in;
            end
            if (burst_q && !beat_q)
            begin
               beat_d = 1'b1;
               addr_d = addr_q + 24'h000002;
               cnt_d = a2d_q;
               st_d = ST_WAIT;
            end
            else
               st_d = ST_DONE;
         end
         ST_DONE:
         begin
            // word already whole; the ack carries it in one response
            cnt_d = rec_q;
            st_d = ST_REC;
         end
         ST_REC:
         begin
            // device gets its recovery before the next select
            if (cnt_q > 5'h01)
               cnt_d = cnt_q - 5'h01;
            else
               st_d = ST_IDLE;
         end
         default:
            st_d = ST_IDLE;
      endcase
   end
   // ----------------------------------------
   // register stage
   // ----------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         win_q[0] <= PBP_WIN_RST;
         win_q[1] <= PBP_WIN_RST;
         tenure_q <= PBP_TENURE_RST;
         st_q <= ST_IDLE;
         cnt_q <= 5'h00;
         own_q <= PBP_MST_CORE;
         wide_q <= 1'b0;
         beat_q <= 1'b0;
         burst_q <= 1'b0;
         a2d_q <= PBP_A2D_DEF;
         rec_q <= PBP_REC_DEF;
         data_q <= 32'h0000_0000;
         addr_q <= 24'h000000;
      end
      else
      begin
         win_q <= win_d;
         tenure_q <= tenure_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         own_q <= own_d;
         wide_q <= wide_d;
         beat_q <= beat_d;
         burst_q <= burst_d;
         a2d_q <= a2d_d;
         rec_q <= rec_d;
         data_q <= data_d;
         addr_q <= addr_d;
      end
   end
   // ----------------------------------------
   // register read, one cycle later
   // ----------------------------------------
   logic [31:0] rd_q, rd_d;
   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            PBP_OFF_WIN0: rd_d = win_q[0];
            PBP_OFF_WIN1: rd_d = win_q[1];
            PBP_OFF_TENURE: rd_d = {24'h000000, tenure_q};
            PBP_OFF_STATUS: rd_d = {24'h000000, burst_q, beat_q, own_q, 4'(cnt_q[3:0])};
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         rd_q <= 32'h0000_0000;
      else
         rd_q <= rd_d;
   end
   assign reg_rdata_out = rd_q;
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // ack pulses as recovery starts; read word already assembled
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_ack
         assign mst_ack_out[gi] = (st_q == ST_DONE) && own_q == 2'(gi);
      end
   endgenerate
   assign mst_rdata_out = data_q;
   always_comb
   begin
      mem_out.addr = addr_q;
      mem_out.dout = wide_q ? (beat_q ? data_q[31:16] : data_q[15:0]) : {8'h00, data_q[7:0]};
      // drive only for writes, so a read never meets a driven bus
      mem_out.dout_en = (st_q == ST_WAIT || st_q == ST_BEAT) && mst_req_in[own_q].write;
      mem_out.cs_b = !(st_q == ST_ADDR || st_q == ST_WAIT || st_q == ST_BEAT);
      mem_out.oe_b = !((st_q == ST_WAIT || st_q == ST_BEAT) && !mst_req_in[own_q].write);
      mem_out.we_b = !(st_q == ST_BEAT && mst_req_in[own_q].write);
   end
endmodule

//--- pbp_pkg.sv
// package for the peripheral bus port: register map, wait codes, types
package pbp_pkg;
   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] PBP_OFF_WIN0 = 8'h00;
   localparam logic [7:0] PBP_OFF_WIN1 = 8'h04;
   localparam logic [7:0] PBP_OFF_TENURE = 8'h08;
   localparam logic [7:0] PBP_OFF_STATUS = 8'h0C;
   // ----------------------------------------
   // window register fields
   // ----------------------------------------
   localparam int PBP_WIN_EN_BIT = 0;
   localparam int PBP_WIN_W16_BIT = 1;
   localparam int PBP_A2D_LSB = 2;
   localparam int PBP_A2D_MSB = 4;
   localparam int PBP_REC_LSB = 6;
   localparam int PBP_REC_MSB = 8;
   localparam int PBP_BASE_LSB = 12;
   localparam logic [31:0] PBP_WIN_RST = 32'h0000_01DC;
   localparam logic [7:0] PBP_TENURE_RST = 8'h98;
   // ----------------------------------------
   // wait-state counts per code
   // ----------------------------------------
   localparam logic [4:0] PBP_A2D_0 = 5'h05;
   localparam logic [4:0] PBP_A2D_1 = 5'h09;
   localparam logic [4:0] PBP_A2D_2 = 5'h0D;
   localparam logic [4:0] PBP_A2D_3 = 5'h11;
   localparam logic [4:0] PBP_A2D_DEF = 5'h15;
   localparam logic [4:0] PBP_REC_0 = 5'h03;
   localparam logic [4:0] PBP_REC_1 = 5'h06;
   localparam logic [4:0] PBP_REC_2 = 5'h0A;
   localparam logic [4:0] PBP_REC_3 = 5'h0E;
   localparam logic [4:0] PBP_REC_4 = 5'h12;
   localparam logic [4:0] PBP_REC_DEF = 5'h16;
   // ----------------------------------------
   // master ids and types
   // ----------------------------------------
   localparam logic [1:0] PBP_MST_CORE = 2'h0;
   localparam logic [1:0] PBP_MST_DMA = 2'h1;
   localparam logic [1:0] PBP_MST_XLAT = 2'h2;
   typedef struct packed
   {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [2:0] size;
      logic [31:0] wdata;
   } pbp_req_t;
   typedef struct packed
   {
      logic [23:0] addr;
      logic [15:0] dout;
      logic dout_en;
      logic cs_b;
      logic oe_b;
      logic we_b;
   } pbp_mem_t;
endpackage

//--- pbp_arb.sv
// core-first arbiter for the internal masters with core tenure timer
`timescale 1ns/1ps
module pbp_arb
   import pbp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // request side
   input wire logic [2:0] req_in,
   input wire logic done_in,
   input wire logic idle_in,
   input wire logic [7:0] tenure_in,
   // grant side
   output logic gnt_vld_out,
   output logic [1:0] gnt_out
);
   import pbp_pkg::*;
   // ----------------------------------------
   // tenure counting
   // ----------------------------------------
   logic [7:0] ten_q, ten_d;
   logic [1:0] last_q, last_d;
   logic [1:0] pick;
   logic others;
   always_comb
   begin
      others = req_in[PBP_MST_DMA] | req_in[PBP_MST_XLAT];
      // core first after any other owner; dma before xlat unless dma went last; core keeps the port only until its tenure ends
      pick = PBP_MST_CORE;
      if (req_in[PBP_MST_CORE] && (!others || (last_q == PBP_MST_CORE && ten_q != 8'h00)
          || last_q != PBP_MST_CORE))
         pick = PBP_MST_CORE;
      else if (req_in[PBP_MST_DMA] && !(last_q == PBP_MST_DMA && req_in[PBP_MST_XLAT]))
         pick = PBP_MST_DMA;
      else if (req_in[PBP_MST_XLAT])
         pick = PBP_MST_XLAT;
      else
         pick = PBP_MST_DMA;
      last_d = last_q;
      ten_d = ten_q;
      if (idle_in && |req_in)
      begin
         last_d = pick;
         // restarts while nobody waits, so it only measures contention
         if (pick != PBP_MST_CORE || last_q != PBP_MST_CORE || !others)
            ten_d = tenure_in;
      end
      else if (done_in && last_q == PBP_MST_CORE && ten_q != 8'h00)
         ten_d = ten_q - 8'h01;
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ten_q <= PBP_TENURE_RST;
         last_q <= PBP_MST_DMA;
      end
      else
      begin
         ten_q <= ten_d;
         last_q <= last_d;
      end
   end
   assign gnt_vld_out = idle_in & |req_in;
   assign gnt_out = pick;
endmodule

//--- pbp_mem_model.sv
// model of a prefetchable flash or sram device on the peripheral bus
`timescale 1ns/1ps
module pbp_mem_model
   import pbp_pkg::*;
(
   // clock
   input wire logic clk_in,
   // memory bus
   input wire pbp_pkg::pbp_mem_t mem_in,
   output logic [15:0] din_out
);
   // ----------------
   // read data
   // ----------------
   logic [15:0] last_q = 16'h0000;
   logic sel;
   // reads have no side effects, so unrequested beats do no harm
   assign sel = !mem_in.cs_b && !mem_in.oe_b;
   // released bus shows the inverse of the last word, never a stale copy
   assign din_out = sel ? (mem_in.addr[15:0] ^ 16'h5A3C) : ~last_q;
   always @(posedge clk_in)
      if (sel)
         last_q <= din_out;
endmodule

//--- pbp_port_asserts.sv
// checker for peripheral bus port timing and arbitration
`timescale 1ns/1ps
module pbp_port_asserts
   import pbp_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   // masters and memory bus
   input wire pbp_pkg::pbp_req_t [2:0] mst_req_in,
   input wire logic [2:0] mst_ack_out,
   input wire pbp_pkg::pbp_mem_t mem_out
);
   // ----------------
   // tenure shadow, core acks while dma waits
   // ----------------
   logic [7:0] ten_q, ten_d, run_q, run_d;
   always_comb
   begin
      ten_d = ten_q;
      run_d = run_q;
      if (reg_wr_in && reg_addr_in == PBP_OFF_TENURE)
         ten_d = reg_wdata_in[7:0];
      if (!mst_req_in[1].valid || mst_ack_out[1])
         run_d = 8'h00;
      else if (mst_ack_out[0] && run_q != 8'hFF)
         run_d = run_q + 8'h01;
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         ten_q <= PBP_TENURE_RST;
         run_q <= 8'h00;
      end
      else
      begin
         ten_q <= ten_d;
         run_q <= run_d;
      end
   end
   // ----------------
   // properties
   // ----------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence s_start;
      $fell(mem_out.cs_b);
   endsequence
   a_ack_single: assert property (|mst_ack_out |=> mst_ack_out == 3'h0)
      else $error("ack held");
   a_ack_onehot: assert property ($onehot0(mst_ack_out))
      else $error("two acks");
   a_ack_after_beat: assert property (|mst_ack_out |-> !$past(mem_out.cs_b))
      else $error("ack without access");
   a_rec_min: assert property (|mst_ack_out |=> mem_out.cs_b [*3])
      else $error("recovery short");
   a_a2d_min: assert property (s_start |-> !mem_out.cs_b [*7])
      else $error("access short");
   a_ack_late: assert property (s_start |=> (mst_ack_out == 3'h0) [*6])
      else $error("ack early");
   a_core_tenure: assert property (run_q <= ten_q)
      else $error("core tenure overrun");
   a_tenure_read: assert property (reg_rd_in && reg_addr_in == PBP_OFF_TENURE |=>
      reg_rdata_out[7:0] == ten_q)
      else $error("tenure read");
   a_write_single: assert property (!mem_out.we_b |-> mem_out.dout_en ##1 mem_out.we_b)
      else $error("write beat");
endmodule
bind pbp_port pbp_port_asserts i_chk (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mst_req_in, .mst_ack_out, .mem_out);

//--- pbp_port_bench.sv
// testbench for the peripheral bus port
`timescale 1ns/1ps
module pbp_port_bench;
   import pbp_pkg::*;
   // ----------------
   // signals
   // ----------------
   typedef struct packed
   {
      logic w16;
      logic [2:0] a2d;
      logic [4:0] a2d_n;
      logic [2:0] rec;
      logic [4:0] rec_n;
      logic [2:0] sz;
      logic [31:0] addr;
   } pbp_row_t;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out, mst_rdata_out, rd_v;
   pbp_req_t [2:0] mst_req_in = '0;
   logic [2:0] mst_ack_out;
   pbp_mem_t mem_out;
   logic [15:0] mem_din_in;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_low, n_gap;
   // byte sizes only on 8-bit rows
   pbp_row_t rows [8] = '{
      '{1'b1, 3'h0, 5'h05, 3'h7, 5'h16, 3'h4, 32'h0000_0010},
      '{1'b0, 3'h1, 5'h09, 3'h6, 5'h16, 3'h1, 32'h0000_0123},
      '{1'b1, 3'h2, 5'h0D, 3'h5, 5'h16, 3'h2, 32'h0000_0A40},
      '{1'b0, 3'h3, 5'h11, 3'h4, 5'h12, 3'h1, 32'h0000_0FFF},
      '{1'b1, 3'h4, 5'h15, 3'h3, 5'h0E, 3'h4, 32'h0000_1238},
      '{1'b0, 3'h5, 5'h15, 3'h2, 5'h0A, 3'h1, 32'h0000_2001},
      '{1'b1, 3'h6, 5'h15, 3'h1, 5'h06, 3'h2, 32'h0000_3334},
      '{1'b0, 3'h7, 5'h15, 3'h0, 5'h03, 3'h1, 32'h0000_FFF5}};
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("CHECK FAILED %0t: got %0h want %0h", $time, got, exp); \
      end \
   end
   pbp_port i_dut (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .mst_req_in, .mst_ack_out, .mst_rdata_out, .mem_out,
      .mem_din_in);
   pbp_mem_model i_mem (.clk_in(clk_sys_in), .mem_in(mem_out), .din_out(mem_din_in));
   always #10 clk_sys_in = ~clk_sys_in;
   // ----------------
   // tasks
   // ----------------
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         failures++;
         stop_test();
      end
   end
   function automatic logic [31:0] exp_rd(input logic w16, input logic [31:0] a);
      logic [15:0] lo, hi;
      lo = a[15:0] ^ 16'h5A3C;
      hi = (a[15:0] + 16'h0002) ^ 16'h5A3C;
      return w16 ? {hi, lo} : {24'h0, lo[7:0]};
   endfunction
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      rd_v = reg_rdata_out;
   endtask
   // core read; counts select cycles before ack and idle cycles before select
   task automatic xfer(input logic [31:0] a, input logic [2:0] sz);
      @(posedge clk_sys_in);
      mst_req_in[0] <= '{1'b1, 1'b0, a, sz, 32'h0};
      n_low = 0;
      n_gap = 0;
      for (int i = 0; i < 300; i++)
      begin
         @(negedge clk_sys_in);
         if (mst_ack_out[0] === 1'b1)
            break;
         if (mem_out.cs_b === 1'b0)
            n_low++;
         else if (n_low == 0)
            n_gap++;
      end
      `CHK(mst_ack_out[0], 1'b1)
      rd_v = mst_rdata_out;
      @(posedge clk_sys_in);
      mst_req_in[0].valid <= 1'b0;
   endtask
   // core writes back to back; dma joins once a core write is in flight
   task automatic race(input int exp_n);
      int nc;
      nc = 0;
      @(posedge clk_sys_in);
      mst_req_in[0] <= '{1'b1, 1'b1, 32'h0000_0100, 3'h1, 32'h0000_00A5};
      wait (mem_out.cs_b === 1'b0);
      @(posedge clk_sys_in);
      mst_req_in[1] <= '{1'b1, 1'b0, 32'h0000_0200, 3'h1, 32'h0};
      for (int i = 0; i < 4000 && mst_ack_out[1] !== 1'b1; i++)
      begin
         @(negedge clk_sys_in);
         if (mst_ack_out[0] === 1'b1)
            nc++;
      end
      @(posedge clk_sys_in);
      mst_req_in <= '0;
      `CHK(nc, exp_n)
   endtask
   // ----------------
   // sequence
   // ----------------
   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      reg_rd(PBP_OFF_WIN0);
      `CHK(rd_v, PBP_WIN_RST)
      reg_rd(PBP_OFF_TENURE);
      `CHK(rd_v[7:0], 8'h98)
      reg_rd(8'h40);
      `CHK(rd_v, 32'h0)
      $display("reset values done");
      foreach (rows[i])
      begin
         reg_wr(PBP_OFF_WIN0, {23'h0, rows[i].rec, 1'b0, rows[i].a2d, rows[i].w16, 1'b0});
         xfer(rows[i].addr, rows[i].sz);
         `CHK(rd_v, exp_rd(rows[i].w16, rows[i].addr))
         `CHK(n_low, 1 + (rows[i].w16 ? 2 : 1) * (rows[i].a2d_n + 1))
         xfer(rows[i].addr + 32'h4, rows[i].sz);
         `CHK(n_gap, int'(rows[i].rec_n))
         $display("row %0d done", i);
      end
      reg_wr(PBP_OFF_WIN1, 32'h0000_4003);
      reg_rd(PBP_OFF_WIN1);
      `CHK(rd_v, 32'h0000_4003)
      xfer(32'h0000_4010, 3'h4);
      `CHK(rd_v, exp_rd(1'b1, 32'h0000_4010))
      `CHK(n_low, 13)
      $display("second window done");
      reg_wr(PBP_OFF_WIN0, 32'h0);
      race(152);
      reg_wr(PBP_OFF_TENURE, 32'h1);
      reg_rd(PBP_OFF_TENURE);
      `CHK(rd_v[7:0], 8'h01)
      race(1);
      $display("arbitration done");
      @(posedge clk_sys_in);
      mst_req_in[0] <= '{1'b1, 1'b0, 32'h0, 3'h1, 32'h0};
      repeat (3) @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      mst_req_in <= '0;
      @(negedge clk_sys_in);
      `CHK({mem_out.cs_b, mst_ack_out}, 4'h8)
      @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      reg_rd(PBP_OFF_TENURE);
      `CHK(rd_v[7:0], 8'h98)
      $display("mid-run reset done");
      stop_test();
   end
endmodule
